// File: host_port_pkg.sv
// shared constants and bus carriers for the host port handshake block
package host_port_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // time the acknowledge is driven high before it floats
  localparam int ACK_RELEASE_NS = 10;
  localparam int ACK_RELEASE_CYC =
    (ACK_RELEASE_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (ACK_RELEASE_NS / CLK_PERIOD_NS);
  // width of the done pulse on a transmit terminal count
  localparam int DONE_TC_NS = 100;
  localparam int DONE_TC_CYC =
    (DONE_TC_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (DONE_TC_NS / CLK_PERIOD_NS);
  localparam int DATA_W = 8;
  localparam int COUNT_W = 16;
  localparam int REL_W = 4;
  localparam int TCH_W = 5;
  localparam logic [REL_W-1:0] REL_LOAD = REL_W'(ACK_RELEASE_CYC - 1);
  localparam logic [TCH_W-1:0] TC_LOAD = TCH_W'(DONE_TC_CYC);
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef struct packed {
    logic chip_select_n;
    logic int_ack_n;
    logic read_cycle;
  } host_bus_t;

  typedef struct packed {
    logic single_mode;
    logic ack_n;
    logic dma_complete_n;
    logic to_tx_queue;
  } dma_bus_t;

  typedef enum logic [2:0] {
    kind_host_wr, kind_host_rd, kind_iack, kind_dma_wr, kind_dma_rd
  } cycle_kind_t;

  typedef enum logic [1:0] {
    ack_idle, ack_wait_data, ack_active, ack_negate
  } ack_state_t;
endpackage

// File: host_bus_handshake_dma_done.sv
// bus acknowledge, single-address dma, done line and sync/rts output
// Summary of operation
// - done low from dma marks last tx write
// - drive done on last rx dma or tc
// - done is open-drain, works in any mode
// - sync output low one bit after sync
// - host write: acknowledge once data captured; dma write: acknowledge at once
// - read or iack: acknowledge with valid data
// - host write data captured at ack or cs
// - negate ack when cs or iack negates
// - after negation the acknowledge floats
// - dma write data taken at complete/dack end
// - dma ack negated on complete or dack high
// - rts changes only on software command
`timescale 1ns/100ps
module host_bus_handshake_dma_done
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire host_bus_t host_bus,
  input wire dma_bus_t dma_bus,
  input wire logic [DATA_W-1:0] bus_data_in,
  input wire logic read_data_ready,
  input wire logic rx_last_dma,
  input wire logic tc_load,
  input wire logic [COUNT_W-1:0] tc_value,
  input wire logic tx_char_sent,
  input wire logic last_transfer_n_i,
  input wire logic sync_select,
  input wire logic sync_detect,
  input wire logic sync_lost,
  input wire logic bit_tick,
  input wire logic rts_assert_cmd,
  input wire logic rts_negate_cmd,
  output logic bus_cycle_ack_n_o,
  output logic bus_cycle_ack_oe,
  output logic last_transfer_n_o,
  output logic last_transfer_oe,
  output logic [DATA_W-1:0] write_data,
  output logic write_strobe,
  output logic write_is_last,
  output logic sync_found_out_n,
  output logic request_send_out_n
);

  ack_state_t state_q;
  cycle_kind_t kind_q;
  logic ack_n_q;
  logic ack_oe_q;
  logic [REL_W-1:0] rel_cnt_q;
  logic [DATA_W-1:0] wr_data_q;
  logic wr_strobe_q;
  logic wr_last_q;
  logic done_seen_q;
  logic rx_hold_q;
  logic [COUNT_W-1:0] tc_cnt_q;
  logic [TCH_W-1:0] tc_hold_q;
  logic done_oe_q;
  logic done_n_q;
  logic sync_arm_q;
  logic sync_on_q;
  logic rts_on_q;
  logic pin_n_q;

  logic dma_start;
  logic end_cond;
  logic bus_quiet;
  logic done_from_far;
  logic done_drive_d;

  // far-end done only counts while our own driver is off
  assign done_from_far = !last_transfer_n_i && !done_oe_q;

  function automatic logic cycle_over(input cycle_kind_t k,
                                      input host_bus_t h,
                                      input dma_bus_t d);
    case (k)
      kind_iack: cycle_over = h.int_ack_n;
      kind_dma_wr, kind_dma_rd:
        cycle_over = !d.dma_complete_n || d.ack_n;
      default: cycle_over = h.chip_select_n;
    endcase
  endfunction

  assign dma_start = dma_bus.single_mode && !dma_bus.ack_n;
  assign end_cond = cycle_over(kind_q, host_bus, dma_bus);
  assign bus_quiet = host_bus.chip_select_n && host_bus.int_ack_n &&
                     dma_bus.ack_n;

  // acknowledge state machine; in short select mode the host simply
  // ignores this output, so it is generated the same way either way
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ack_idle;
      kind_q <= kind_host_wr;
      ack_n_q <= 1'b1;
      ack_oe_q <= 1'b0;
      rel_cnt_q <= '0;
    end else begin
      case (state_q)
        ack_idle: begin
          ack_oe_q <= 1'b0;
          ack_n_q <= 1'b1;
          if (dma_start) begin
            if (dma_bus.to_tx_queue) begin
              kind_q <= kind_dma_wr;
              state_q <= ack_active;
              ack_n_q <= 1'b0;
              ack_oe_q <= 1'b1;
            end else begin
              kind_q <= kind_dma_rd;
              state_q <= ack_wait_data;
            end
          end else if (!host_bus.int_ack_n) begin
            kind_q <= kind_iack;
            state_q <= ack_wait_data;
          end else if (!host_bus.chip_select_n) begin
            if (host_bus.read_cycle) begin
              kind_q <= kind_host_rd;
              state_q <= ack_wait_data;
            end else begin
              kind_q <= kind_host_wr;
              state_q <= ack_active;
              ack_n_q <= 1'b0;
              ack_oe_q <= 1'b1;
            end
          end
        end
        ack_wait_data: begin
          if (end_cond) begin
            state_q <= ack_negate;
            rel_cnt_q <= '0;
          end else if (read_data_ready) begin
            state_q <= ack_active;
            ack_n_q <= 1'b0;
            ack_oe_q <= 1'b1;
          end
        end
        ack_active: begin
          if (end_cond) begin
            ack_n_q <= 1'b1;
            state_q <= ack_negate;
            rel_cnt_q <= REL_LOAD;
          end
        end
        ack_negate: begin
          // drive high briefly before floating so the line rises fast
          if (rel_cnt_q != '0) begin
            rel_cnt_q <= rel_cnt_q - 1'b1;
          end else begin
            ack_oe_q <= 1'b0;
            if (bus_quiet) begin
              state_q <= ack_idle;
            end
          end
        end
        default: begin
          state_q <= ack_idle;
          ack_n_q <= 1'b1;
          ack_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // write data capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_data_q <= DATA_RST;
      wr_strobe_q <= 1'b0;
      wr_last_q <= 1'b0;
    end else begin
      wr_strobe_q <= 1'b0;
      // host write: ack falls in the capture cycle, so the earlier of
      // ack or select rise is always this edge
      if (state_q == ack_idle && !dma_start && host_bus.int_ack_n &&
          !host_bus.chip_select_n && !host_bus.read_cycle) begin
        wr_data_q <= bus_data_in;
        wr_strobe_q <= 1'b1;
        wr_last_q <= 1'b0;
      end else if (state_q == ack_active && kind_q == kind_dma_wr &&
                   end_cond) begin
        wr_data_q <= bus_data_in;
        wr_strobe_q <= 1'b1;
        wr_last_q <= done_seen_q || done_from_far;
      end
    end
  end

  // remember a far-end done seen in a dma write cycle after its starting edge (cleared while idle)
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_seen_q <= 1'b0;
    end else if (state_q == ack_idle) begin
      done_seen_q <= 1'b0;
    end else if (kind_q == kind_dma_wr && done_from_far) begin
      done_seen_q <= 1'b1;
    end
  end

  // done held for the whole last rx dma read cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_hold_q <= 1'b0;
    end else if (state_q == ack_idle && dma_start &&
                 !dma_bus.to_tx_queue && rx_last_dma) begin
      rx_hold_q <= 1'b1;
    end else if (state_q == ack_negate) begin
      rx_hold_q <= 1'b0;
    end
  end

  // transmit character counter; terminal count fires a done pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tc_cnt_q <= '0;
      tc_hold_q <= '0;
    end else begin
      if (tc_load) begin
        tc_cnt_q <= tc_value;
      end else if (tx_char_sent && tc_cnt_q != '0) begin
        tc_cnt_q <= tc_cnt_q - COUNT_ONE;
      end
      // fires only on the 1 to 0 step, so a zero load never fires
      if (!tc_load && tx_char_sent && tc_cnt_q == COUNT_ONE) begin
        tc_hold_q <= TC_LOAD;
      end else if (tc_hold_q != '0) begin
        tc_hold_q <= tc_hold_q - 1'b1;
      end
    end
  end

  // done is active in dma and non-dma modes alike
  assign done_drive_d = rx_hold_q || (tc_hold_q != '0);

  // open drain: data is low whenever the enable is on, the enable alone pulls the line
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_oe_q <= 1'b0;
      done_n_q <= 1'b1;
    end else begin
      done_oe_q <= done_drive_d;
      done_n_q <= !done_drive_d;
    end
  end

  // sync found: armed on detect, shown at the next bit boundary
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_arm_q <= 1'b0;
      sync_on_q <= 1'b0;
    end else begin
      if (sync_lost) begin
        sync_arm_q <= 1'b0;
        sync_on_q <= 1'b0;
      end
      // a detect or a due bit tick in the same cycle beats a loss
      if (sync_detect) begin
        sync_arm_q <= 1'b1;
      end else if (sync_arm_q && bit_tick) begin
        sync_arm_q <= 1'b0;
        sync_on_q <= 1'b1;
      end
    end
  end

  // request to send follows software commands only; assert wins a tie
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rts_on_q <= 1'b0;
    end else if (rts_assert_cmd) begin
      rts_on_q <= 1'b1;
    end else if (rts_negate_cmd) begin
      rts_on_q <= 1'b0;
    end
  end

  // shared pin: select picks sync output or rts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_n_q <= 1'b1;
    end else begin
      pin_n_q <= sync_select ? !sync_on_q : !rts_on_q;
    end
  end

  assign bus_cycle_ack_n_o = ack_n_q;
  assign bus_cycle_ack_oe = ack_oe_q;
  assign last_transfer_n_o = done_n_q;
  assign last_transfer_oe = done_oe_q;
  assign write_data = wr_data_q;
  assign write_strobe = wr_strobe_q;
  assign write_is_last = wr_last_q;
  assign sync_found_out_n = pin_n_q;
  assign request_send_out_n = pin_n_q;

endmodule // host_bus_handshake_dma_done

// File: hs_props.sv
// assertions on the host port handshake block
`timescale 1ns/100ps
module hs_props
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire host_bus_t host_bus,
  input wire dma_bus_t dma_bus,
  input wire logic [DATA_W-1:0] bus_data_in,
  input wire logic read_data_ready,
  input wire logic bus_cycle_ack_n_o,
  input wire logic bus_cycle_ack_oe,
  input wire logic last_transfer_n_o,
  input wire logic last_transfer_oe,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic write_strobe
);
  logic ak;
  logic dend;
  assign ak = !bus_cycle_ack_n_o && bus_cycle_ack_oe;
  // host quiet, so only complete or acknowledge release can end it
  assign dend = host_bus.chip_select_n && host_bus.int_ack_n &&
    (!dma_bus.dma_complete_n || dma_bus.ack_n);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_end;
    ($rose(host_bus.chip_select_n) || $rose(host_bus.int_ack_n)) && ak
      |=> bus_cycle_ack_n_o;
  endproperty
  a_end: assert property (p_end) else $error("ack held");
  property p_dend; ak && dend |=> bus_cycle_ack_n_o; endproperty
  a_dend: assert property (p_dend) else $error("dma ack held");
  property p_flt; bus_cycle_ack_oe && bus_cycle_ack_n_o |=> !bus_cycle_ack_oe;
  endproperty
  a_flt: assert property (p_flt) else $error("ack not floated");
  property p_on; $rose(bus_cycle_ack_oe) |-> !bus_cycle_ack_n_o; endproperty
  a_on: assert property (p_on) else $error("ack driven high");
  property p_wr;
    $rose(ak) && !host_bus.chip_select_n && !host_bus.read_cycle
      |-> write_strobe && write_data == bus_data_in;
  endproperty
  a_wr: assert property (p_wr) else $error("write not taken");
  property p_rd;
    $rose(ak) && dma_bus.ack_n && (!host_bus.int_ack_n || host_bus.read_cycle)
      |-> $past(read_data_ready);
  endproperty
  a_rd: assert property (p_rd) else $error("read ack early");
  property p_dcap;
    ak && dend && !$past(dma_bus.ack_n) && dma_bus.to_tx_queue
      |=> write_strobe && write_data == $past(bus_data_in);
  endproperty
  a_dcap: assert property (p_dcap) else $error("dma data lost");
  property p_od; last_transfer_oe |-> !last_transfer_n_o; endproperty
  a_od: assert property (p_od) else $error("done driven high");
  cover property (write_strobe);
  cover property (last_transfer_oe);
  cover property (ak && !dma_bus.ack_n);
endmodule // hs_props
bind host_bus_handshake_dma_done hs_props i_props (.*);

// File: bus_model.sv
// processor and dma controller model on the far side of the host port
`timescale 1ns/100ps
module bus_model
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic ack_wire,
  output host_bus_t host_bus,
  output dma_bus_t dma_bus,
  output logic [DATA_W-1:0] bus_data_in,
  output logic done_drive_n
);
  initial begin
    host_bus = 3'h6;
    dma_bus = 4'he;
    bus_data_in = 8'h00;
    done_drive_n = 1'b1;
  end
  // request held until ack seen low, then w wait states
  task automatic cyc(input cycle_kind_t k, input logic [7:0] d,
    input logic [1:0] w, input logic last, output int n);
    bus_data_in = d;
    host_bus = {k > kind_host_rd, k != kind_iack, k == kind_host_rd};
    dma_bus = {1'b1, k < kind_dma_wr, 1'b1, k == kind_dma_wr};
    done_drive_n = !last;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_wire !== 1'b0 && n < 40);
    repeat (w) @(posedge ref_clk);
    #1;
    // odd w ends a dma cycle by complete, even by acknowledge release
    if (!dma_bus.ack_n && w[0]) begin
      dma_bus.dma_complete_n = 1'b0;
      @(posedge ref_clk);
      #1;
    end
    host_bus[2:1] = 2'h3;
    dma_bus[2:1] = 2'h3;
    done_drive_n = 1'b1;
    // data outlives the strobes by one edge for a late capture
    @(posedge ref_clk);
    #1;
    bus_data_in = ~d;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // short select host: select timing alone ends the cycle
  task automatic short_wr(input logic [7:0] d);
    bus_data_in = d;
    host_bus = 3'h2;
    dma_bus = 4'he;
    repeat (2) @(posedge ref_clk);
    #1;
    host_bus = 3'h6;
    @(posedge ref_clk);
    #1;
    bus_data_in = ~d;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
endmodule // bus_model

// File: tb_host_bus_handshake_dma_done.sv
// self-checking bench for the host port handshake block
`timescale 1ns/100ps
module tb_host_bus_handshake_dma_done;
  import host_port_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, read_data_ready = 1'b0;
  logic rx_last_dma = 1'b0, tc_load = 1'b0, tx_char_sent = 1'b0;
  logic sync_select = 1'b1, sync_detect = 1'b0, sync_lost = 1'b0;
  logic bit_tick = 1'b0, rts_assert_cmd = 1'b0, rts_negate_cmd = 1'b0;
  logic [COUNT_W-1:0] tc_value = 16'h0003;
  host_bus_t host_bus;
  dma_bus_t dma_bus;
  logic [DATA_W-1:0] bus_data_in, write_data, got_d;
  logic bus_cycle_ack_n_o, bus_cycle_ack_oe, last_transfer_n_o, got_last;
  logic last_transfer_oe, write_strobe, write_is_last, done_drive_n;
  logic sync_found_out_n, request_send_out_n, ack_wire, last_transfer_n_i;
  logic [31:0] seed = 32'hca98;
  logic [4:0] idle_view;
  int n_mismatch = 0, tests_run = 0, n_strobe = 0, n_done = 0, d0;
  host_bus_handshake_dma_done i_dut (.*);
  bus_model i_bus (.*);
  always #5 ref_clk = ~ref_clk;
  // both open lines rest high through their pull-ups
  assign ack_wire = bus_cycle_ack_oe ? bus_cycle_ack_n_o : 1'b1;
  assign last_transfer_n_i = !last_transfer_oe && done_drive_n;
  assign idle_view = {bus_cycle_ack_oe, last_transfer_oe, write_strobe,
                      bus_cycle_ack_n_o, sync_found_out_n};
  always @(posedge ref_clk) begin
    if (write_strobe === 1'b1) begin
      n_strobe <= n_strobe + 1;
      got_d <= write_data;
      got_last <= write_is_last;
    end
    if (last_transfer_oe === 1'b1) n_done <= n_done + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic is_wr(input cycle_kind_t k);
    return k == kind_host_wr || k == kind_dma_wr;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic xfer(input cycle_kind_t k, input logic [7:0] d,
    input logic [1:0] w, input logic last);
    int n;
    int s0;
    logic [15:0] e;
    s0 = n_strobe;
    e = 16'({last && k == kind_dma_wr, d});
    d0 = n_done;
    rx_last_dma = last;
    fork
      i_bus.cyc(k, d, w, last && k == kind_dma_wr, n);
      begin
        tick(2);
        read_data_ready = 1'b1;
      end
    join
    read_data_ready = 1'b0;
    if (n >= 40) begin
      chk(16'h0000, 16'h0001);
      results;
    end else begin
      if (is_wr(k)) chk(16'(n), 16'h0002);
      else chk(16'(n), 16'h0004);
      chk(16'(n_strobe - s0), 16'(is_wr(k)));
      chk(16'(n_done != d0), 16'(last && k == kind_dma_rd));
      chk(16'(bus_cycle_ack_oe), 16'h0000);
      if (is_wr(k)) chk(16'({got_last, got_d}), e);
    end
  endtask
  initial begin
    tick(3);
    chk(16'(idle_view), 16'h0003);
    rst = 1'b0;
    tick(1);
    chk(16'(idle_view), 16'h0003);
    for (int i = 0; i < 20; i++)
      xfer(cycle_kind_t'(i % 5), 8'(i), 2'(i / 5), i[0]);
    repeat (40) begin
      seed = xs(seed);
      xfer(cycle_kind_t'(seed[2:0] % 3'h5), seed[15:8], seed[5:4], seed[6]);
    end
    seed = xs(seed);
    d0 = n_strobe;
    i_bus.short_wr(seed[7:0]);
    chk(16'(n_strobe - d0), 16'h0001);
    chk(16'(got_d), 16'(seed[7:0]));
    chk(16'(bus_cycle_ack_oe), 16'h0000);
    pulse(tc_load);
    d0 = n_done;
    for (int i = 0; i < 3; i++) begin
      chk(16'(n_done - d0), 16'h0000);
      pulse(tx_char_sent);
    end
    tick(20);
    chk(16'(n_done - d0), 16'(DONE_TC_CYC));
    pulse(sync_detect);
    tick(3);
    chk(16'(sync_found_out_n), 16'h0001);
    pulse(bit_tick);
    tick(1);
    chk(16'(sync_found_out_n), 16'h0000);
    pulse(sync_lost);
    sync_select = 1'b0;
    tick(2);
    chk(16'(request_send_out_n), 16'h0001);
    pulse(rts_assert_cmd);
    tick(4);
    chk(16'(request_send_out_n), 16'h0000);
    pulse(rts_negate_cmd);
    tick(1);
    chk(16'(request_send_out_n), 16'h0001);
    results;
  end
endmodule // tb_host_bus_handshake_dma_done
